// file: hdl/pcrs_top.sv
`timescale 1ns/100ps
// Purpose: Program counter, high-byte latch and circular return stack
// Assumes: Decoder issues at most one operation per cycle; priority resolves overlap
// Notes:   Pop takes two cycles because the stack memory read is registered
module pcrs_top
   import pcrs_pkg::*;
(
   input  wire logic               sys_clk,                // Core clock
   input  wire logic               rst,                    // Synchronous reset, any source
   input  wire logic               pc_advance,             // Increment counter
   input  wire logic               low_wr,                 // Software writes low byte
   input  wire logic [LOW_W-1:0]   low_wdata,              // Low byte write data
   input  wire logic               latch_wr,               // Software writes high latch
   input  wire logic [LATCH_W-1:0] latch_wdata,            // High latch write data
   input  wire logic               jump_op,                // Jump instruction
   input  wire logic               call_op,                // Call instruction
   input  wire logic [TGT_W-1:0]   target,                 // Instruction target bits
   input  wire logic               irq_vector,             // Interrupt forces branch
   input  wire logic [PC_W-1:0]    vector_addr,            // Interrupt vector address
   input  wire logic               return_op,              // Plain return
   input  wire logic               return_with_literal_op, // Return with literal
   input  wire logic               interrupt_return_op,    // Return from interrupt
   output logic      [PC_W-1:0]    fetch_addr,             // Program counter
   output logic      [LOW_W-1:0]   pc_low_byte_reg,        // Low byte readback
   output logic      [LATCH_W-1:0] pc_high_latch,          // Latch readback
   output logic                    busy                    // Pop in progress
);
   ////////////////////////////////////////////////////////////////////////////
   logic [PC_W-1:0]    pc_r;        // Program counter
   logic [LATCH_W-1:0] latch_r;     // High-byte latch
   logic [SP_W-1:0]    sp_r;        // Next free stack slot
   logic               pop_pend_r;  // Reload cycle of a pop
   logic [PC_W-1:0]    stk_rdata;   // Registered stack read
   logic               do_push;     // Push taken this cycle
   logic               do_pop;      // Pop taken this cycle

   // Page form for call and jump
   function automatic logic [PC_W-1:0] paged(input logic [LATCH_W-1:0] l,
                                             input logic [TGT_W-1:0] t);
      paged = {l[PAGE_MSB:PAGE_LSB], t}; // RQ4
   endfunction

   // Push on call or vectoring; pop on any return kind
   assign do_push = !pop_pend_r && (call_op || irq_vector); // RQ6
   assign do_pop  = !pop_pend_r && !do_push &&
                    (return_op || return_with_literal_op || interrupt_return_op); // RQ7
   assign busy    = pop_pend_r;

   ////////////////////////////////////////////////////////////////////////////
   // Stack memory: push writes slot sp, pop reads slot sp-1 (modulo eight)
   pcrs_stack_mem u_mem // RQ5
   (
      .sys_clk (sys_clk),
      .wr_en   (do_push),
      .wr_addr (sp_r),
      .wr_data (pc_r),
      .rd_addr (sp_r - 3'h1),
      .rd_data (stk_rdata)
   );

   // Stack pointer wraps both ways; no overflow flag by design
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         sp_r <= SP_RESET;
      else if (do_push)
         sp_r <= sp_r + 3'h1; // RQ9 RQ10
      else if (do_pop)
         sp_r <= sp_r - 3'h1; // RQ14
   end

   // Pop waits one cycle for registered read data
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         pop_pend_r <= 1'b0;
      else
         pop_pend_r <= do_pop;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Latch is only written by software, never by stack traffic
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         latch_r <= LATCH_RESET;
      else if (latch_wr)
         latch_r <= latch_wdata; // RQ8
   end

   // Program counter; 13 bits span the 8K space with natural wrap
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         pc_r <= PC_RESET; // RQ2
      else if (pop_pend_r)
         pc_r <= stk_rdata; // RQ7
      else if (irq_vector)
         pc_r <= vector_addr;
      else if (call_op || jump_op)
         pc_r <= paged(latch_r, target); // RQ4
      else if (low_wr)
         pc_r <= {latch_r[UPPER_W-1:0], low_wdata}; // RQ3
      else if (pc_advance)
         pc_r <= pc_r + 13'h0001; // RQ12
   end

   // Only the low byte is visible; upper bits have no readback
   assign fetch_addr      = pc_r; // RQ1
   assign pc_low_byte_reg = pc_r[LOW_W-1:0];
   assign pc_high_latch   = latch_r;

   ////////////////////////////////////////////////////////////////////////////
   // Any reset leaves the counter at zero on the next edge
   property p_reset_clear;
      @(posedge sys_clk) rst |=> pc_r == PC_RESET;
   endproperty
   a_reset_clear: assert property (p_reset_clear) // RQ2
      else $error("pc not cleared");

   // A lone low write splices the latch bits above the written byte
   property p_low_load;
      @(posedge sys_clk) disable iff (rst)
         low_wr && !pop_pend_r && !irq_vector && !call_op && !jump_op
         |=> pc_r == {$past(latch_r[UPPER_W-1:0]), $past(low_wdata)};
   endproperty
   a_low_load: assert property (p_low_load) // RQ3
      else $error("low write load wrong");

   // Call and jump stay inside the page chosen by the latch
   property p_paged;
      @(posedge sys_clk) disable iff (rst)
         (call_op || jump_op) && !pop_pend_r && !irq_vector
         |=> pc_r == {$past(latch_r[PAGE_MSB:PAGE_LSB]), $past(target)};
   endproperty
   a_paged: assert property (p_paged) // RQ4
      else $error("paged load wrong");

   // Pointer steps up on every push and wraps past slot seven
   property p_push_sp;
      @(posedge sys_clk) disable iff (rst)
         do_push |=> sp_r == $past(sp_r) + 3'h1;
   endproperty
   a_push_sp: assert property (p_push_sp) // RQ9
      else $error("push pointer wrong");

   // Pointer steps down on every pop and wraps below slot zero
   property p_pop_sp;
      @(posedge sys_clk) disable iff (rst)
         do_pop |=> sp_r == $past(sp_r) - 3'h1;
   endproperty
   a_pop_sp: assert property (p_pop_sp) // RQ14
      else $error("pop pointer wrong");

   // Push, one quiet cycle, then pop gives back the pushed address
   property p_roundtrip;
      @(posedge sys_clk) disable iff (rst)
         do_push ##1 (!do_push && !do_pop) ##1 do_pop
         |=> ##1 pc_r == $past(pc_r, 4);
   endproperty
   a_roundtrip: assert property (p_roundtrip) // RQ7
      else $error("return address wrong");

   // Stack traffic, reload cycle included, never moves the latch
   property p_latch_keep;
      @(posedge sys_clk) disable iff (rst)
         (do_push || do_pop || pop_pend_r) && !latch_wr |=> latch_r == $past(latch_r);
   endproperty
   a_latch_keep: assert property (p_latch_keep) // RQ8
      else $error("latch disturbed");

   // Busy lasts exactly one cycle after a pop is taken
   property p_pop_one;
      @(posedge sys_clk) disable iff (rst)
         do_pop |=> pop_pend_r ##1 !pop_pend_r;
   endproperty
   a_pop_one: assert property (p_pop_one) // RQ7
      else $error("pop timing wrong");

   // A lone advance steps the counter by one through the 8K space
   property p_adv_step;
      @(posedge sys_clk) disable iff (rst)
         pc_advance && !pop_pend_r && !irq_vector && !call_op && !jump_op && !low_wr
         |=> pc_r == $past(pc_r) + 13'h0001;
   endproperty
   a_adv_step: assert property (p_adv_step) // RQ12
      else $error("advance step wrong");

   // Outside the reload cycle, vectoring loads the vector address whatever else is asked
   property p_vector_load;
      @(posedge sys_clk) disable iff (rst)
         irq_vector && !pop_pend_r |=> pc_r == $past(vector_addr);
   endproperty
   a_vector_load: assert property (p_vector_load) // RQ6
      else $error("vector load wrong");

   // While busy no push or pop may move the pointer
   property p_busy_sp;
      @(posedge sys_clk) disable iff (rst)
         pop_pend_r |=> sp_r == $past(sp_r);
   endproperty
   a_busy_sp: assert property (p_busy_sp) // RQ7
      else $error("pointer moved while busy");

   // Reload cycle takes all 13 bits from the stack read port
   property p_pop_reload;
      @(posedge sys_clk) disable iff (rst)
         pop_pend_r |=> pc_r == $past(stk_rdata);
   endproperty
   a_pop_reload: assert property (p_pop_reload) // RQ7
      else $error("pop reload wrong");

   // Software latch write lands on the next edge
   property p_latch_load;
      @(posedge sys_clk) disable iff (rst)
         latch_wr |=> latch_r == $past(latch_wdata);
   endproperty
   a_latch_load: assert property (p_latch_load) // RQ3
      else $error("latch write lost");

   // A push in the same cycle as a return drops the pop
   property p_push_wins;
      @(posedge sys_clk) disable iff (rst)
         (call_op || irq_vector) && !pop_pend_r |=> !pop_pend_r;
   endproperty
   a_push_wins: assert property (p_push_wins) // RQ6
      else $error("pop taken beside push");

   // Main scenarios: push, pop reload, low write, pointer wrap
   c_call: cover property (@(posedge sys_clk) do_push);
   c_ret: cover property (@(posedge sys_clk) pop_pend_r);
   c_low: cover property (@(posedge sys_clk) low_wr && !pop_pend_r);
   c_wrap: cover property (@(posedge sys_clk) do_push && sp_r == 3'h7);
endmodule

// file: shared/pcrs_pkg.sv
// Purpose: Constants for the program counter and return stack block
// Assumes: One core clock, synchronous active-high reset
// Notes:   Functional notes follow
// Functional notes
// (RQ1) Program counter is 13 bits; low byte readable and writable, upper bits hidden.
// (RQ2) Any reset clears the program counter to zero.
// (RQ3) Low-byte write loads counter bits 12..8 from latch bits 4..0.
// (RQ4) Call and jump take 11 bits from instruction, top two from latch 4..3.
// (RQ5) Return stack holds eight 13-bit entries; pointer hidden from software.
// (RQ6) Call or interrupt vectoring pushes the program counter.
// (RQ7) Any return kind pops the stack and reloads all 13 counter bits.
// (RQ8) Push and pop never touch the high-byte latch.
// (RQ9) Stack is circular; ninth push overwrites first, tenth the second.
// (RQ10) No overflow or underflow status exists.
// (RQ11) Software computed jumps do not carry past a 256-word block.
// (RQ12) Counter addresses a contiguous 8K-word program space.
// (RQ13) Software sets latch page bits before cross-page call or jump.
// (RQ14) Pointer wraps modulo eight on pops as well as pushes.
package pcrs_pkg;
   localparam int PC_W        = 13;
   localparam int LOW_W       = 8;
   localparam int UPPER_W     = 5;
   localparam int LATCH_W     = 8;
   localparam int TGT_W       = 11;
   localparam int PAGE_LSB    = 3;
   localparam int PAGE_MSB    = 4;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W        = 3;
   localparam logic [PC_W-1:0]    PC_RESET    = 13'h0000;
   localparam logic [LATCH_W-1:0] LATCH_RESET = 8'h00;
   localparam logic [SP_W-1:0]    SP_RESET    = 3'h0;
endpackage

// file: hdl/pcrs_stack_mem.sv
`timescale 1ns/100ps
// Purpose: Eight-entry return address memory with registered read
// Assumes: Write and read addresses supplied by the owner
// Notes:   Contents are not reset; the read port registers mem[rd_addr] every cycle, written or not
module pcrs_stack_mem
   import pcrs_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH,
   parameter int AW    = SP_W,
   parameter int DW    = PC_W
)
(
   input  wire logic          sys_clk,  // Core clock
   input  wire logic          wr_en,    // Write strobe
   input  wire logic [AW-1:0] wr_addr,  // Write slot
   input  wire logic [DW-1:0] wr_data,  // Address to store
   input  wire logic [AW-1:0] rd_addr,  // Read slot
   output logic      [DW-1:0] rd_data   // Registered read data
);
   logic [DW-1:0] mem [DEPTH];

   // Store a return address
   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
   end

   // Registered read port
   always_ff @(posedge sys_clk)
   begin
      rd_data <= mem[rd_addr];
   end
endmodule

// file: bench/pcrs_dec_model.sv
`timescale 1ns/100ps
// Purpose: Decoder and interrupt side model, one op strobe per call
// Assumes: op bits: advance, low, latch, jump, call, irq, ret, ret-lit, int-ret
// Notes:   Released data is inverted so a stale value never looks valid
module pcrs_dec_model
   import pcrs_pkg::*;
(
   input  wire logic            sys_clk, // Core clock
   output logic      [8:0]      op,      // One-hot op strobes
   output logic      [PC_W-1:0] arg      // Data, target or vector
);
   initial
   begin
      op  = 9'h000;
      arg = 13'h0000;
   end
   // Strobe rises and falls on falling edges so the rising edge sees it settled
   task automatic issue(input int k, input logic [PC_W-1:0] a);
      @(negedge sys_clk);
      op[k] = 1'b1;
      arg   = a;
      @(negedge sys_clk);
      op  = 9'h000;
      arg = ~a;
   endtask
endmodule

// file: bench/testbench.sv
`timescale 1ns/100ps
// Purpose: Self-checking bench for program counter and return stack
// Assumes: Ops come from the decoder model at falling edges
// Notes:   Expected addresses are worked out here from the paging rules
module testbench
   import pcrs_pkg::*;
;
   logic            sys_clk;
   logic            rst;
   logic [8:0]      op;
   logic [PC_W-1:0] arg;
   logic [PC_W-1:0] fetch_addr;
   logic [7:0]      low_q;
   logic [7:0]      latch_q;
   logic            busy;
   int              fail_count;
   int              total_checks;
   //////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   pcrs_dec_model dec_u (.sys_clk(sys_clk), .op(op), .arg(arg));
   pcrs_top dut_u (.sys_clk(sys_clk), .rst(rst), .pc_advance(op[0]), .low_wr(op[1]),
      .low_wdata(arg[7:0]), .latch_wr(op[2]), .latch_wdata(arg[7:0]), .jump_op(op[3]),
      .call_op(op[4]), .target(arg[10:0]), .irq_vector(op[5]), .vector_addr(arg),
      .return_op(op[6]), .return_with_literal_op(op[7]), .interrupt_return_op(op[8]),
      .fetch_addr(fetch_addr), .pc_low_byte_reg(low_q), .pc_high_latch(latch_q),
      .busy(busy));
   // One compare for every result; all results fit in the counter width
   task automatic chk(input string nm, input logic [PC_W-1:0] e, input logic [PC_W-1:0] g);
      total_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic reset_dut(input int n);
      @(negedge sys_clk);
      rst = 1'b1;
      repeat (n) @(negedge sys_clk);
      rst = 1'b0;
      chk("fetch after reset", 13'h0000, fetch_addr);
      chk("latch after reset", 13'h0000, {5'h00, latch_q});
      chk("busy after reset", 13'h0000, {12'h000, busy});
   endtask
   // Return kinds take two cycles; next op waits out the busy cycle
   task automatic pop(input int k, input logic [PC_W-1:0] e, input logic [PC_W-1:0] lat);
      dec_u.issue(k, 13'h0000);
      chk("busy after return", 13'h0001, {12'h000, busy});
      @(negedge sys_clk);
      chk("fetch after return", e, fetch_addr);
      chk("latch after return", lat, {5'h00, latch_q});
   endtask
   task automatic t_paging();
      dec_u.issue(2, 13'h001a);
      dec_u.issue(1, 13'h0034);
      chk("fetch after low write", 13'h1a34, fetch_addr);
      chk("low byte readback", 13'h0034, {5'h00, low_q});
      dec_u.issue(0, 13'h0000);
      chk("fetch after advance", 13'h1a35, fetch_addr);
      // Computed jump adding d0 to 35: the low byte wraps, the block stays
      dec_u.issue(1, 13'h0005);
      chk("fetch after computed jump", 13'h1a05, fetch_addr);
      dec_u.issue(2, 13'h001b);
      dec_u.issue(1, 13'h0005);
      chk("fetch after block step", 13'h1b05, fetch_addr);
      dec_u.issue(2, 13'h0018);
      dec_u.issue(3, 13'h07ff);
      chk("fetch after jump", 13'h1fff, fetch_addr);
      dec_u.issue(2, 13'h0008);
      dec_u.issue(4, 13'h0123);
      chk("fetch after call", 13'h0923, fetch_addr);
      dec_u.issue(5, 13'h0004);
      chk("fetch after vector", 13'h0004, fetch_addr);
      pop(8, 13'h0923, 13'h0008);
      pop(6, 13'h1fff, 13'h0008);
      $display("test paging done");
   endtask
   // Ten calls overrun the eight slots; pops then walk back and wrap
   task automatic t_wrap();
      reset_dut(1);
      dec_u.issue(2, 13'h0018);
      for (int k = 0; k < 10; k++)
         dec_u.issue(4, 13'(k + 1));
      for (int j = 0; j < 9; j++)
         pop(6 + j % 3, 13'h1800 + 13'((j == 8) ? 9 : 9 - j), 13'h0018);
      $display("test wrap done");
   endtask
   initial
   begin
      rst = 1'b1;
      fail_count = 0;
      total_checks = 0;
      reset_dut(8);
      t_paging();
      t_wrap();
      report_and_stop();
   end
   // Whole run needs well under 200 cycles
   initial
   begin
      repeat (2000) @(posedge sys_clk);
      fail_count++;
      $display("ERROR watchdog expected done seen hang");
      report_and_stop();
   end
endmodule
